// [timer8_pkg.sv]
// constants and types shared by the 8-bit timer/counter files
package timer8_pkg;
   // register byte offsets on the wishbone bus
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_COUNT = 8'h04;
   localparam logic [7:0] OFS_COMPARE = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0C;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_ASYNC = 8'h14;
   // field positions
   localparam int CTRL_CS_LSB = 0;
   localparam int CTRL_WAVE_LSB = 3;
   localparam int CTRL_COM_LSB = 5;
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;
   localparam int ASYNC_SEL_BIT = 0;
   // reset values
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COMPARE_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] ASYNC_RST = 8'h00;
   // count extremes
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   // prescaler masks: tick when the masked prescaler bits are all ones
   localparam logic [9:0] PRE_MASK_1 = 10'h000;
   localparam logic [9:0] PRE_MASK_8 = 10'h007;
   localparam logic [9:0] PRE_MASK_32 = 10'h01F;
   localparam logic [9:0] PRE_MASK_64 = 10'h03F;
   localparam logic [9:0] PRE_MASK_128 = 10'h07F;
   localparam logic [9:0] PRE_MASK_256 = 10'h0FF;
   localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;
   localparam logic [2:0] CS_STOPPED = 3'h0;
   // waveform modes and compare output modes
   typedef enum logic [1:0] {
      WAVE_NORMAL = 2'b00,
      WAVE_PHASE_PWM = 2'b01,
      WAVE_CTC = 2'b10,
      WAVE_FAST_PWM = 2'b11
   } wave_mode_t;
   typedef enum logic [1:0] {
      COM_OFF = 2'b00,
      COM_TOGGLE = 2'b01,
      COM_CLEAR = 2'b10,
      COM_SET = 2'b11
   } out_mode_t;
endpackage

// [timer_core_if.sv]
// signals between the counter unit and the compare/waveform unit
`timescale 1ns/1ns
interface timer_core_if;
   logic timer_tick;
   logic [7:0] count_value;
   logic [7:0] compare_value;
   logic [7:0] compare_active;
   logic count_down;
   logic match;
   logic wave_state;
   timer8_pkg::wave_mode_t wave_mode;
   timer8_pkg::out_mode_t out_mode;
   modport counter (output timer_tick, count_value, compare_value, count_down, wave_mode,
                    out_mode, input compare_active, match, wave_state);
   modport compare (input timer_tick, count_value, compare_value, count_down, wave_mode,
                    out_mode, output compare_active, match, wave_state);
endinterface

// [timer_tick_gen.sv]
// tick source: i/o clock or synchronised crystal edges, then prescaler
`timescale 1ns/1ns
module timer_tick_gen (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // crystal pins
   input wire logic crystal_in_pin_in,
   output logic crystal_out_pin_out,
   // selection
   input wire logic async_clock_select_in,
   input wire logic [2:0] clock_select_field_in,
   // tick
   output logic timer_tick_out
);
   logic [2:0] xtal_sync_ff;
   logic [9:0] prescale_ff;
   logic xtal_level_ff;
   logic src_pulse;
   logic [9:0] mask;

   // three-stage synchroniser; only stages two and three are compared
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xtal_sync_ff <= 3'h0;
      end else begin
         xtal_sync_ff <= {xtal_sync_ff[1:0], crystal_in_pin_in};
      end
   end

   // feedback to the oscillator pin, inverted as an amplifier would
   assign crystal_out_pin_out = ~xtal_sync_ff[2];

   // accepted crystal level; moves only once stages two and three agree
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         xtal_level_ff <= 1'b0;
      end else if (xtal_sync_ff[1] == xtal_sync_ff[2]) begin
         xtal_level_ff <= xtal_sync_ff[2];
      end
   end

   // source pulse: every cycle, or once per accepted crystal rise
   assign src_pulse = async_clock_select_in ?
                      (xtal_sync_ff[2] & xtal_sync_ff[1] & ~xtal_level_ff) : 1'b1;

   // divider position to tick on
   always_comb begin
      unique case (clock_select_field_in)
         3'h1: mask = timer8_pkg::PRE_MASK_1;
         3'h2: mask = timer8_pkg::PRE_MASK_8;
         3'h3: mask = timer8_pkg::PRE_MASK_32;
         3'h4: mask = timer8_pkg::PRE_MASK_64;
         3'h5: mask = timer8_pkg::PRE_MASK_128;
         3'h6: mask = timer8_pkg::PRE_MASK_256;
         3'h7: mask = timer8_pkg::PRE_MASK_1024;
         default: mask = timer8_pkg::PRE_MASK_1;
      endcase
   end

   // free-running prescaler, cleared to zero while stopped so a restart is clean
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prescale_ff <= 10'h000;
      end else if (clock_select_field_in == timer8_pkg::CS_STOPPED) begin
         prescale_ff <= 10'h000;
      end else if (src_pulse) begin
         prescale_ff <= prescale_ff + 10'h001;
      end
   end

   // no tick at all with the stopped selection
   assign timer_tick_out = (clock_select_field_in != timer8_pkg::CS_STOPPED) & src_pulse
                           & ((prescale_ff & mask) == mask);
endmodule

// [compare_wave_unit.sv]
// double-buffered compare, comparator and waveform generator
`timescale 1ns/1ns
module compare_wave_unit (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // link to the counter unit
   timer_core_if.compare core
);
   logic pwm_mode;
   logic at_max;
   logic at_bottom;

   assign pwm_mode = (core.wave_mode == timer8_pkg::WAVE_PHASE_PWM) |
                     (core.wave_mode == timer8_pkg::WAVE_FAST_PWM);
   assign at_max = core.count_value == timer8_pkg::COUNT_MAX;
   assign at_bottom = core.count_value == timer8_pkg::COUNT_BOTTOM;

   // active buffer: follows software at once outside pwm, at max in pwm
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core.compare_active <= timer8_pkg::COMPARE_RST;
      end else if (!pwm_mode || (core.timer_tick && at_max)) begin
         core.compare_active <= core.compare_value;
      end
   end

   // comparator runs all the time
   assign core.match = core.count_value == core.compare_active;

   // internal output state; moves only while an output mode enables the pin, holds otherwise
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core.wave_state <= 1'b0;
      end else if (core.timer_tick && core.out_mode != timer8_pkg::COM_OFF) begin
         unique case (core.wave_mode)
            timer8_pkg::WAVE_NORMAL, timer8_pkg::WAVE_CTC: begin
               if (core.match) begin
                  core.wave_state <= (core.out_mode == timer8_pkg::COM_TOGGLE) ?
                     ~core.wave_state : (core.out_mode == timer8_pkg::COM_SET);
               end
            end
            timer8_pkg::WAVE_FAST_PWM: begin
               // at max the match level wins, so compare at max gives a flat line
               if (core.match) begin
                  core.wave_state <= (core.out_mode == timer8_pkg::COM_SET);
               end else if (at_max && core.out_mode != timer8_pkg::COM_TOGGLE) begin
                  core.wave_state <= (core.out_mode == timer8_pkg::COM_CLEAR);
               end
            end
            timer8_pkg::WAVE_PHASE_PWM: begin
               // up-count match clears (non-inverted), down-count or bottom sets
               if (core.match && core.out_mode != timer8_pkg::COM_TOGGLE) begin
                  core.wave_state <= (core.count_down | at_bottom) ^
                                     (core.out_mode == timer8_pkg::COM_SET);
               end
            end
         endcase
      end
   end
endmodule

// [timer8_count_compare_unit.sv]
// 8-bit timer/counter with one compare channel and a wishbone register port
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ns
module timer8_count_compare_unit (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // wishbone slave
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   // interrupt requests and service acknowledges
   output logic overflow_irq_out,
   output logic compare_irq_out,
   input wire logic overflow_irq_ack_in,
   input wire logic compare_irq_ack_in,
   // compare output pin override
   output logic compare_output_out,
   output logic compare_output_en_out,
   // crystal oscillator pins
   input wire logic crystal_in_pin_in,
   output logic crystal_out_pin_out
);
   timer_core_if core ();

   // software registers
   logic [7:0] control_ff;
   logic [7:0] count_ff;
   logic [7:0] compare_ff;
   logic [7:0] mask_ff;
   logic [7:0] async_ff;
   logic overflow_flag_ff;
   logic compare_flag_ff;
   logic count_down_ff;
   logic wb_ack_ff;
   logic [7:0] rd_data_ff;

   // bus decode
   logic bus_req;
   logic wr_en;
   logic wr_lane;
   logic wr_control;
   logic wr_count;
   logic wr_compare;
   logic wr_flag;
   logic wr_mask;
   logic wr_async;
   logic [7:0] rd_data;

   // counter unit internals
   logic [2:0] clock_select_field;
   logic async_clock_select;
   logic timer_tick;
   logic [7:0] top_value;
   logic at_top;
   logic at_bottom;
   logic at_max;
   logic ctr_clear;
   logic ctr_count;
   logic nxt_count_down;
   logic [7:0] nxt_count;
   logic overflow_event;
   logic compare_event;
   logic clr_overflow;

   // field extraction
   assign clock_select_field = control_ff[timer8_pkg::CTRL_CS_LSB +: 3];
   assign async_clock_select = async_ff[timer8_pkg::ASYNC_SEL_BIT];
   // mode fields reach the compare unit over the link
   assign core.wave_mode = timer8_pkg::wave_mode_t'(control_ff[timer8_pkg::CTRL_WAVE_LSB +: 2]);
   assign core.out_mode = timer8_pkg::out_mode_t'(control_ff[timer8_pkg::CTRL_COM_LSB +: 2]);

   // tick source and prescaler
   timer_tick_gen timer_tick_gen_i (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .crystal_in_pin_in(crystal_in_pin_in),
      .crystal_out_pin_out(crystal_out_pin_out),
      .async_clock_select_in(async_clock_select),
      .clock_select_field_in(clock_select_field),
      .timer_tick_out(timer_tick)
   );

   // compare and waveform unit
   compare_wave_unit compare_wave_unit_i (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .core(core)
   );

   // counter side of the link
   assign core.timer_tick = timer_tick;
   assign core.count_value = count_ff;
   assign core.compare_value = compare_ff;
   assign core.count_down = count_down_ff;

   // ---- wishbone slave ----

   // one request per cycle/strobe pair; ack comes one cycle after the strobe
   assign bus_req = wb_cyc_in & wb_stb_in;

   // a write lands on the edge where the master sees ack
   assign wr_en = bus_req & wb_we_in & wb_ack_ff;

   // only byte lane zero carries register data
   assign wr_lane = wr_en & wb_sel_in[0];

   // one select per register offset
   assign wr_control = wr_lane & (wb_adr_in == timer8_pkg::OFS_CONTROL);
   assign wr_count = wr_lane & (wb_adr_in == timer8_pkg::OFS_COUNT);
   assign wr_compare = wr_lane & (wb_adr_in == timer8_pkg::OFS_COMPARE);
   assign wr_flag = wr_lane & (wb_adr_in == timer8_pkg::OFS_FLAG);
   assign wr_mask = wr_lane & (wb_adr_in == timer8_pkg::OFS_MASK);
   assign wr_async = wr_lane & (wb_adr_in == timer8_pkg::OFS_ASYNC);

   // ack pulses high for one cycle, drops even if the master is slow to release
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack_ff <= 1'b0;
      end else begin
         wb_ack_ff <= bus_req & ~wb_ack_ff;
      end
   end

   // ack from a flop, no path from the strobe
   assign wb_ack_out = wb_ack_ff;

   // read mux; unmapped offsets answer with zero
   always_comb begin
      unique case (wb_adr_in)
         timer8_pkg::OFS_CONTROL: rd_data = control_ff;
         timer8_pkg::OFS_COUNT: rd_data = count_ff;
         timer8_pkg::OFS_COMPARE: rd_data = compare_ff;
         timer8_pkg::OFS_FLAG: begin
            rd_data = 8'h00;
            rd_data[timer8_pkg::FLAG_OVF_BIT] = overflow_flag_ff;
            rd_data[timer8_pkg::FLAG_CMP_BIT] = compare_flag_ff;
         end
         timer8_pkg::OFS_MASK: rd_data = mask_ff;
         timer8_pkg::OFS_ASYNC: rd_data = async_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // read data is captured with the request so it stands steady under ack
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_ff <= 8'h00;
      end else if (bus_req & ~wb_ack_ff) begin
         rd_data_ff <= rd_data;
      end
   end

   // upper lanes always read zero
   assign wb_dat_out = {24'h000000, rd_data_ff};

   // ---- configuration registers ----

   // control: clock select, wave mode, output mode
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         control_ff <= timer8_pkg::CONTROL_RST;
      end else if (wr_control) begin
         control_ff <= wb_dat_in[7:0];
      end
   end

   // interrupt mask bits
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mask_ff <= timer8_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= wb_dat_in[7:0];
      end
   end

   // asynchronous clock select; only the select bit is kept
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         async_ff <= timer8_pkg::ASYNC_RST;
      end else if (wr_async) begin
         async_ff <= 8'h00;
         async_ff[timer8_pkg::ASYNC_SEL_BIT] <= wb_dat_in[timer8_pkg::ASYNC_SEL_BIT];
      end
   end

   // software side of the compare buffer
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         compare_ff <= timer8_pkg::COMPARE_RST;
      end else if (wr_compare) begin
         compare_ff <= wb_dat_in[7:0];
      end
   end

   // ---- counter unit ----

   // top is max, or the compare value in clear-on-compare mode
   assign top_value = (core.wave_mode == timer8_pkg::WAVE_CTC) ? core.compare_active
                                                               : timer8_pkg::COUNT_MAX;
   // extremes for the sequence and the overflow point
   assign at_top = count_ff == top_value;
   assign at_bottom = count_ff == timer8_pkg::COUNT_BOTTOM;
   assign at_max = count_ff == timer8_pkg::COUNT_MAX;

   // clear only in clear-on-compare mode at a match; output mode plays no part
   assign ctr_clear = (core.wave_mode == timer8_pkg::WAVE_CTC) & core.match;
   // every tick is a step; the stopped selection never ticks
   assign ctr_count = timer_tick;

   // sequence selection per wave mode
   always_comb begin
      nxt_count = count_ff;
      nxt_count_down = count_down_ff;
      if (ctr_count) begin
         unique case (core.wave_mode)
            timer8_pkg::WAVE_NORMAL, timer8_pkg::WAVE_FAST_PWM: begin
               // no clear here; the wrap marks overflow
               nxt_count = count_ff + 8'h01;
               nxt_count_down = 1'b0;
            end
            timer8_pkg::WAVE_CTC: begin
               // the clear replaces the step, compare is top
               nxt_count = ctr_clear ? timer8_pkg::COUNT_BOTTOM : count_ff + 8'h01;
               nxt_count_down = 1'b0;
            end
            timer8_pkg::WAVE_PHASE_PWM: begin
               // turn around at top and at bottom
               if (!count_down_ff && at_top) begin
                  nxt_count_down = 1'b1;
               end else if (count_down_ff && at_bottom) begin
                  nxt_count_down = 1'b0;
               end
               nxt_count = nxt_count_down ? count_ff - 8'h01 : count_ff + 8'h01;
            end
         endcase
      end
   end

   // count register; a software write beats the tick in the same cycle
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_ff <= timer8_pkg::COUNT_RST;
      end else if (wr_count) begin
         count_ff <= wb_dat_in[7:0];
      end else begin
         count_ff <= nxt_count;
      end
   end

   // direction follows the sequence even across a count write
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_down_ff <= 1'b0;
      end else begin
         count_down_ff <= nxt_count_down;
      end
   end

   // ---- flags ----

   // overflow: at max wrap in up modes, at bottom turn in phase pwm
   always_comb begin
      overflow_event = 1'b0;
      // a same-cycle count write takes the event away
      if (timer_tick && !wr_count) begin
         if (core.wave_mode == timer8_pkg::WAVE_PHASE_PWM) begin
            overflow_event = count_down_ff & at_bottom;
         end else begin
            overflow_event = at_max & ~ctr_clear;
         end
      end
   end

   // match registers into the flag at the tick seen with the match
   assign compare_event = timer_tick & core.match & ~wr_count;

   // service pulse or write-one; loses to a same-cycle event
   assign clr_overflow = overflow_irq_ack_in | (wr_flag & wb_dat_in[timer8_pkg::FLAG_OVF_BIT]);

   // overflow flag; a new event wins over a same-cycle clear
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         overflow_flag_ff <= 1'b0;
      end else if (overflow_event) begin
         overflow_flag_ff <= 1'b1;
      end else if (clr_overflow) begin
         overflow_flag_ff <= 1'b0;
      end
   end

   // compare flag; write-one clears, write-zero leaves it
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         compare_flag_ff <= 1'b0;
      end else if (compare_event) begin
         compare_flag_ff <= 1'b1;
      end else if (compare_irq_ack_in) begin
         compare_flag_ff <= 1'b0;
      end else if (wr_flag && wb_dat_in[timer8_pkg::FLAG_CMP_BIT]) begin
         compare_flag_ff <= 1'b0;
      end
   end

   // each request gated by its own mask bit
   assign overflow_irq_out = overflow_flag_ff & mask_ff[timer8_pkg::FLAG_OVF_BIT];
   assign compare_irq_out = compare_flag_ff & mask_ff[timer8_pkg::FLAG_CMP_BIT];

   // ---- pin override ----

   // pin is taken over whenever an output mode is chosen
   assign compare_output_en_out = core.out_mode != timer8_pkg::COM_OFF;
   assign compare_output_out = core.wave_state;
endmodule

// [timer8_props.sv]
// concurrent checks on the timer/counter top-level ports
`timescale 1ns/1ns
module timer8_props (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // register bus
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   // interrupts, compare pin, crystal
   input wire logic overflow_irq_out,
   input wire logic compare_irq_out,
   input wire logic compare_output_out,
   input wire logic compare_output_en_out,
   input wire logic crystal_in_pin_in,
   input wire logic crystal_out_pin_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // bus answers: one cycle late, one cycle wide, never unasked
   ack_timing_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack wider than one cycle");
   idle_no_ack_a: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
      else $error("ack without request");
   // registers are one byte wide; offsets above 0x14 read as zero
   read_width_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
      else $error("read data above byte lane");
   unmapped_read_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h14
      |-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
   // clearing the mask silences both requests at once
   mask_gate_a: assert property (wb_ack_out && wb_we_in && wb_sel_in[0]
      && wb_adr_in == timer8_pkg::OFS_MASK && wb_dat_in[1:0] == 2'b00
      |=> !overflow_irq_out && !compare_irq_out) else $error("irq ignores mask");
   // pin override follows the output mode field
   out_enable_a: assert property (wb_ack_out && wb_we_in && wb_sel_in[0]
      && wb_adr_in == timer8_pkg::OFS_CONTROL
      |=> compare_output_en_out == (|$past(wb_dat_in[6:5]))) else $error("pin enable wrong");
   // mode zero: the output state must not move at a match
   out_hold_a: assert property (!compare_output_en_out |=> $stable(compare_output_out))
      else $error("output state moved with mode off");
   // crystal input echoed inverted after synchronising
   xtal_echo_a: assert property ($rose(crystal_in_pin_in)
      |-> ##[1:5] $fell(crystal_out_pin_out)) else $error("crystal echo missing");
endmodule

// [xtal_osc_model.sv]
// watch crystal stand-in: one slow pulse per request, low between
`timescale 1ns/1ns
module xtal_osc_model (
   // clock
   input wire logic core_clk_in,
   // control from bench
   input wire logic pulse_req_in,
   // crystal pins
   output logic crystal_in_pin_out,
   input wire logic crystal_out_pin_in
);
   initial crystal_in_pin_out = 1'b0;
   // pulse kept far slower than core/2 so the synchroniser sees it
   always @(posedge core_clk_in) begin
      if (pulse_req_in) begin
         crystal_in_pin_out <= 1'b1;
         repeat (8) @(posedge core_clk_in);
         crystal_in_pin_out <= 1'b0;
      end
   end
endmodule

// [timer8_count_compare_unit_tb_top.sv]
// self-checking bench for the 8-bit timer/counter
`timescale 1ns/1ns
module timer8_count_compare_unit_tb_top;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
   logic [7:0] wb_adr_in = 8'h00;
   logic [3:0] wb_sel_in = 4'hF;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd;
   logic wb_ack_out, overflow_irq_out, compare_irq_out, compare_output_out;
   logic compare_output_en_out, crystal_in_pin_in, crystal_out_pin_out, obit;
   logic overflow_irq_ack_in = 1'b0, compare_irq_ack_in = 1'b0, xtal_req = 1'b0;
   logic [7:0] snap;
   int n_errors = 0;
   int total_checks = 0;
   always #10 core_clk_in = ~core_clk_in;
   timer8_count_compare_unit timer8_count_compare_unit_i (.core_clk_in, .rst_n_in,
      .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
      .wb_ack_out, .overflow_irq_out, .compare_irq_out, .overflow_irq_ack_in,
      .compare_irq_ack_in, .compare_output_out, .compare_output_en_out, .crystal_in_pin_in,
      .crystal_out_pin_out);
   xtal_osc_model xtal_osc_model_i (.core_clk_in, .pulse_req_in(xtal_req),
      .crystal_in_pin_out(crystal_in_pin_in), .crystal_out_pin_in(crystal_out_pin_out));
   task automatic final_report();
      $display("errors %0d of %0d checks", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // classic cycle: hold until ack, release on the ack edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_sel_in <= 4'hF;
      wb_adr_in <= a;
      wb_dat_in <= {24'h0, d};
      do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   // watchdog: whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk_in);
      n_errors++;
      final_report();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rc(timer8_pkg::OFS_CONTROL, timer8_pkg::CONTROL_RST);
      rc(timer8_pkg::OFS_COUNT, timer8_pkg::COUNT_RST);
      rc(timer8_pkg::OFS_COMPARE, timer8_pkg::COMPARE_RST);
      rc(timer8_pkg::OFS_MASK, timer8_pkg::MASK_RST);
      rc(timer8_pkg::OFS_ASYNC, timer8_pkg::ASYNC_RST);
      rc(8'h18, 8'h00);
      wr(timer8_pkg::OFS_COUNT, 8'hA5);
      repeat (30) @(posedge core_clk_in);
      rc(timer8_pkg::OFS_COUNT, 8'hA5);
      wr(timer8_pkg::OFS_COMPARE, 8'h05);
      rc(timer8_pkg::OFS_COMPARE, 8'h05);
      // normal mode through the wrap and past the compare value
      wr(timer8_pkg::OFS_COUNT, 8'hF0);
      wr(timer8_pkg::OFS_CONTROL, 8'h01);
      repeat (40) @(posedge core_clk_in);
      wr(timer8_pkg::OFS_CONTROL, 8'h00);
      rc(timer8_pkg::OFS_FLAG, 8'h03);
      bus(1'b0, timer8_pkg::OFS_COUNT, 8'h00);
      snap = rd[7:0];
      chk({24'h0, snap}, 32'h1B);
      repeat (20) @(posedge core_clk_in);
      rc(timer8_pkg::OFS_COUNT, snap);
      wr(timer8_pkg::OFS_FLAG, 8'h00);
      rc(timer8_pkg::OFS_FLAG, 8'h03);
      // service pulses clear one flag each
      wr(timer8_pkg::OFS_MASK, 8'h03);
      @(negedge core_clk_in);
      chk({30'h0, overflow_irq_out, compare_irq_out}, 32'h3);
      @(posedge core_clk_in) overflow_irq_ack_in <= 1'b1;
      @(posedge core_clk_in) overflow_irq_ack_in <= 1'b0;
      @(negedge core_clk_in);
      chk({30'h0, overflow_irq_out, compare_irq_out}, 32'h1);
      @(posedge core_clk_in) compare_irq_ack_in <= 1'b1;
      @(posedge core_clk_in) compare_irq_ack_in <= 1'b0;
      rc(timer8_pkg::OFS_FLAG, 8'h00);
      wr(timer8_pkg::OFS_MASK, 8'h00);
      // clear-on-compare with toggle output
      wr(timer8_pkg::OFS_COUNT, 8'h00);
      wr(timer8_pkg::OFS_COMPARE, 8'h10);
      wr(timer8_pkg::OFS_CONTROL, 8'h31);
      repeat (84) @(posedge core_clk_in);
      @(negedge core_clk_in);
      chk({31'h0, compare_output_en_out}, 32'h1);
      wr(timer8_pkg::OFS_CONTROL, 8'h30);
      // 87 ticks, period 17: five matches, count left at 2
      rc(timer8_pkg::OFS_COUNT, 8'h02);
      rc(timer8_pkg::OFS_FLAG, 8'h02);
      wr(timer8_pkg::OFS_FLAG, 8'h02);
      rc(timer8_pkg::OFS_FLAG, 8'h00);
      @(negedge core_clk_in);
      obit = compare_output_out;
      chk({31'h0, obit}, 32'h1);
      wr(timer8_pkg::OFS_CONTROL, 8'h00);
      @(negedge core_clk_in);
      chk({30'h0, compare_output_en_out, compare_output_out}, {31'h0, obit});
      // divide by eight: ten ticks up to the stop write
      wr(timer8_pkg::OFS_COUNT, 8'h00);
      wr(timer8_pkg::OFS_CONTROL, 8'h02);
      repeat (77) @(posedge core_clk_in);
      wr(timer8_pkg::OFS_CONTROL, 8'h00);
      rc(timer8_pkg::OFS_COUNT, 8'h0A);
      // phase pwm: up from 0xF0, turn at max, forty ticks end at 0xE6
      wr(timer8_pkg::OFS_COUNT, 8'hF0);
      wr(timer8_pkg::OFS_CONTROL, 8'h09);
      repeat (37) @(posedge core_clk_in);
      wr(timer8_pkg::OFS_CONTROL, 8'h00);
      rc(timer8_pkg::OFS_COUNT, 8'hE6);
      rc(timer8_pkg::OFS_FLAG, 8'h00);
      wr(timer8_pkg::OFS_COUNT, 8'h00);
      // crystal source: no ticks without pulses, one per pulse
      wr(timer8_pkg::OFS_ASYNC, 8'h01);
      wr(timer8_pkg::OFS_CONTROL, 8'h01);
      repeat (50) @(posedge core_clk_in);
      rc(timer8_pkg::OFS_COUNT, 8'h00);
      repeat (5) begin
         @(posedge core_clk_in) xtal_req <= 1'b1;
         @(posedge core_clk_in) xtal_req <= 1'b0;
         repeat (25) @(posedge core_clk_in);
      end
      rc(timer8_pkg::OFS_COUNT, 8'h05);
      rc(timer8_pkg::OFS_ASYNC, 8'h01);
      final_report();
   end
endmodule
bind timer8_count_compare_unit timer8_props timer8_props_i (.core_clk_in, .rst_n_in,
   .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out,
   .wb_ack_out, .overflow_irq_out, .compare_irq_out, .compare_output_out,
   .compare_output_en_out, .crystal_in_pin_in, .crystal_out_pin_out);
